// file: rtl/usdp_pkg.sv
// Shared constants of the shadow data port block
package usdp_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] USDP_ALIAS_BASE    = 32'h5000_1130;
    localparam logic [31:0] USDP_ALIAS_7_ADDR  = 32'h5000_114C;
    localparam logic [31:0] USDP_ALIAS_8_ADDR  = 32'h5000_1150;
    localparam logic [31:0] USDP_ALIAS_LAST    = 32'h5000_116C;
    localparam logic [31:0] USDP_LSR_ADDR      = 32'h5000_1170;
    localparam logic [31:0] USDP_CTRL_ADDR     = 32'h5000_1174;
    localparam logic [31:0] USDP_ISR_ADDR      = 32'h5000_1178;
    localparam logic [31:0] USDP_IMR_ADDR      = 32'h5000_117C;
    localparam int          USDP_ALIAS_COUNT   = 16;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int USDP_LSR_DR_BIT      = 0;
    localparam int USDP_LSR_OE_BIT      = 1;
    localparam int USDP_LSR_TRANSMIT_HOLDING_EMPTY_FLAG_BIT    = 5;
    localparam int USDP_CTRL_FIFO_BIT   = 0;
    localparam int USDP_CTRL_IR_BIT     = 1;
    localparam int USDP_EV_RX_BIT       = 0;
    localparam int USDP_EV_OVR_BIT      = 1;
    localparam int USDP_EV_TRANSMIT_HOLDING_EMPTY_FLAG_BIT     = 2;
    localparam int USDP_EV_TXLOST_BIT   = 3;
    localparam int USDP_EV_WIDTH        = 4;

    // ------------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [1:0]  USDP_CTRL_RESET    = 2'h0;
    localparam logic [3:0]  USDP_EV_RESET      = 4'h0;
    localparam logic [7:0]  USDP_BYTE_RESET    = 8'h00;
    localparam logic [31:0] USDP_WORD_ZERO     = 32'h0000_0000;
    localparam int          USDP_FIFO_DEPTH    = 16;

endpackage : usdp_pkg

// file: rtl/usdp_shadow_port.sv
// Shadow data port: aliased receive buffer / transmit holding window
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Sixteen aliased words reach same data path
// - Read returns received byte from UART/IR
// - FIFO off: new byte overwrites, flags overrun
// - FIFO on: read pops oldest receive entry
// - Full receive FIFO drops new byte, overrun
// - Write supplies byte to serial or IR output
// - FIFO off: write clears holding-empty flag
// - FIFO off: further writes replace pending byte
// - FIFO on: accept writes up to depth
// - Write to full transmit FIFO is discarded
module usdp_shadow_port
    import usdp_pkg::*;
#(
    parameter int DEPTH = USDP_FIFO_DEPTH
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [7:0]  rx_uart_byte,
    input  wire logic        rx_uart_valid,
    input  wire logic [7:0]  rx_ir_byte,
    input  wire logic        rx_ir_valid,
    output logic      [7:0]  tx_byte,
    output logic             tx_uart_valid,
    output logic             tx_ir_valid,
    input  wire logic        tx_ready,
    output logic             ir_mode,
    output logic             irq
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);
    localparam logic [CW-1:0] CNT_ZERO = CW'(0);
    localparam logic [PW-1:0] PTR_ONE  = PW'(1);
    localparam logic [PW-1:0] PTR_ZERO = PW'(0);

    // Pointers wrap by overflow, so the depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("usdp_shadow_port: DEPTH must be a power of two, at least 2");
    end

    // Decode trusts the span; a moved bound would silently drop aliases
    if (USDP_ALIAS_LAST - USDP_ALIAS_BASE != 32'((USDP_ALIAS_COUNT - 1) * 4)) begin : g_span_check
        $error("usdp_shadow_port: alias window does not match alias count");
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic alias_hit;
    logic lsr_hit;
    logic ctrl_hit;
    logic isr_hit;
    logic imr_hit;

    assign alias_hit = (reg_addr >= USDP_ALIAS_BASE) && (reg_addr <= USDP_ALIAS_LAST)
                       && (reg_addr[1:0] == 2'h0);
    assign lsr_hit   = (reg_addr == USDP_LSR_ADDR);
    assign ctrl_hit  = (reg_addr == USDP_CTRL_ADDR);
    assign isr_hit   = (reg_addr == USDP_ISR_ADDR);
    assign imr_hit   = (reg_addr == USDP_IMR_ADDR);

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [1:0] ctrl_ff;
    logic       fifo_en;
    logic       flush;

    assign fifo_en = ctrl_ff[USDP_CTRL_FIFO_BIT];
    assign ir_mode = ctrl_ff[USDP_CTRL_IR_BIT];
    // Switching FIFO mode flushes both paths; stale entries would mislead
    assign flush   = reg_wr && ctrl_hit && (reg_wdata[USDP_CTRL_FIFO_BIT] != fifo_en);

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_ff <= USDP_CTRL_RESET;
        end else if (reg_wr && ctrl_hit) begin
            ctrl_ff <= reg_wdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    logic [7:0]    rx_mem [DEPTH];
    logic [PW-1:0] rx_rd_ptr_ff;
    logic [PW-1:0] rx_wr_ptr_ff;
    logic [CW-1:0] rx_cnt_ff;
    logic          rx_in_valid;
    logic [7:0]    rx_in_byte;
    logic          rx_pop;
    logic          rx_push;
    logic          rx_overrun;
    logic          data_ready;

    assign rx_in_valid = ir_mode ? rx_ir_valid : rx_uart_valid;
    assign rx_in_byte  = ir_mode ? rx_ir_byte  : rx_uart_byte;
    assign data_ready  = (rx_cnt_ff != CNT_ZERO);
    assign rx_pop      = reg_rd && alias_hit && data_ready;
    // A pop in the same cycle makes room for the arriving byte
    assign rx_push     = rx_in_valid && (!fifo_en || rx_cnt_ff != CNT_FULL || rx_pop);
    assign rx_overrun  = rx_in_valid && data_ready && !rx_pop
                         && (!fifo_en || rx_cnt_ff == CNT_FULL);

    always_ff @(posedge clock) begin
        if (rst || flush) begin
            rx_rd_ptr_ff <= PTR_ZERO;
            rx_wr_ptr_ff <= PTR_ZERO;
            rx_cnt_ff    <= CNT_ZERO;
        end else if (!fifo_en) begin
            // Single buffer at slot zero; a new byte overwrites it
            if (rx_push) begin
                rx_cnt_ff <= CNT_ONE;
            end else if (rx_pop) begin
                rx_cnt_ff <= CNT_ZERO;
            end
        end else begin
            if (rx_pop) begin
                rx_rd_ptr_ff <= rx_rd_ptr_ff + PTR_ONE;
            end
            if (rx_push) begin
                rx_wr_ptr_ff <= rx_wr_ptr_ff + PTR_ONE;
            end
            if (rx_push && !rx_pop) begin
                rx_cnt_ff <= rx_cnt_ff + CNT_ONE;
            end else if (rx_pop && !rx_push) begin
                rx_cnt_ff <= rx_cnt_ff - CNT_ONE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rx_push && !flush) begin
            rx_mem[fifo_en ? rx_wr_ptr_ff : PTR_ZERO] <= rx_in_byte;
        end
    end

    // ------------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------------
    logic [7:0]    tx_mem [DEPTH];
    logic [PW-1:0] tx_rd_ptr_ff;
    logic [PW-1:0] tx_wr_ptr_ff;
    logic [CW-1:0] tx_cnt_ff;
    logic          tx_wr;
    logic          tx_take;
    logic          tx_push;
    logic          tx_lost;
    logic          transmit_holding_empty_flag;
    logic          tx_pending;

    assign tx_wr      = reg_wr && alias_hit;
    assign tx_pending = (tx_cnt_ff != CNT_ZERO);
    assign transmit_holding_empty_flag       = !tx_pending;
    assign tx_take    = tx_pending && tx_ready;
    assign tx_push    = tx_wr && (!fifo_en || tx_cnt_ff != CNT_FULL);
    assign tx_lost    = tx_wr && fifo_en && tx_cnt_ff == CNT_FULL;

    always_ff @(posedge clock) begin
        if (rst || flush) begin
            tx_rd_ptr_ff <= PTR_ZERO;
            tx_wr_ptr_ff <= PTR_ZERO;
            tx_cnt_ff    <= CNT_ZERO;
        end else if (!fifo_en) begin
            // A write arriving with the take leaves the new byte pending
            if (tx_push) begin
                tx_cnt_ff <= CNT_ONE;
            end else if (tx_take) begin
                tx_cnt_ff <= CNT_ZERO;
            end
        end else begin
            if (tx_take) begin
                tx_rd_ptr_ff <= tx_rd_ptr_ff + PTR_ONE;
            end
            if (tx_push) begin
                tx_wr_ptr_ff <= tx_wr_ptr_ff + PTR_ONE;
            end
            if (tx_push && !tx_take) begin
                tx_cnt_ff <= tx_cnt_ff + CNT_ONE;
            end else if (tx_take && !tx_push) begin
                tx_cnt_ff <= tx_cnt_ff - CNT_ONE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (tx_push && !flush) begin
            // Only the low byte is kept
            tx_mem[fifo_en ? tx_wr_ptr_ff : PTR_ZERO] <= reg_wdata[7:0];
        end
    end

    // Byte comes straight from the storage flops
    assign tx_byte       = tx_mem[fifo_en ? tx_rd_ptr_ff : PTR_ZERO];
    assign tx_uart_valid = tx_pending && !ir_mode;
    assign tx_ir_valid   = tx_pending && ir_mode;

    // ------------------------------------------------------------------
    // Line status and interrupts
    // ------------------------------------------------------------------
    logic                    overrun_ff;
    logic                    transmit_holding_empty_flag_d_ff;
    logic [USDP_EV_WIDTH-1:0] isr_ff;
    logic [USDP_EV_WIDTH-1:0] imr_ff;
    logic [USDP_EV_WIDTH-1:0] events;

    always_ff @(posedge clock) begin
        if (rst) begin
            transmit_holding_empty_flag_d_ff <= 1'b1;
        end else begin
            transmit_holding_empty_flag_d_ff <= transmit_holding_empty_flag;
        end
    end

    always_comb begin
        events                     = USDP_EV_RESET;
        events[USDP_EV_RX_BIT]     = rx_push;
        events[USDP_EV_OVR_BIT]    = rx_overrun;
        events[USDP_EV_TRANSMIT_HOLDING_EMPTY_FLAG_BIT]   = transmit_holding_empty_flag && !transmit_holding_empty_flag_d_ff;
        events[USDP_EV_TXLOST_BIT] = tx_lost;
    end

    // Set wins over the read that clears
    always_ff @(posedge clock) begin
        if (rst) begin
            overrun_ff <= 1'b0;
        end else if (rx_overrun) begin
            overrun_ff <= 1'b1;
        end else if (reg_rd && lsr_hit) begin
            overrun_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            isr_ff <= USDP_EV_RESET;
        end else if (reg_rd && isr_hit) begin
            isr_ff <= events;
        end else begin
            isr_ff <= isr_ff | events;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            imr_ff <= USDP_EV_RESET;
        end else if (reg_wr && imr_hit) begin
            imr_ff <= reg_wdata[USDP_EV_WIDTH-1:0];
        end
    end

    assign irq = |(isr_ff & imr_ff);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [31:0] nxt_rdata;

    always_comb begin
        nxt_rdata = USDP_WORD_ZERO;
        if (alias_hit) begin
            // Buffer content returned even when not valid; data-ready qualifies it
            nxt_rdata[7:0] = rx_mem[fifo_en ? rx_rd_ptr_ff : PTR_ZERO];
        end else if (lsr_hit) begin
            nxt_rdata[USDP_LSR_DR_BIT]   = data_ready;
            nxt_rdata[USDP_LSR_OE_BIT]   = overrun_ff;
            nxt_rdata[USDP_LSR_TRANSMIT_HOLDING_EMPTY_FLAG_BIT] = transmit_holding_empty_flag;
        end else if (ctrl_hit) begin
            nxt_rdata[1:0] = ctrl_ff;
        end else if (isr_hit) begin
            nxt_rdata[USDP_EV_WIDTH-1:0] = isr_ff;
        end else if (imr_hit) begin
            nxt_rdata[USDP_EV_WIDTH-1:0] = imr_ff;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !reg_rd) begin
            reg_rdata <= USDP_WORD_ZERO;
        end else begin
            reg_rdata <= nxt_rdata;
        end
    end

endmodule : usdp_shadow_port

`default_nettype wire

// file: testbench/tb_usdp_shadow_port.sv
// Self-checking bench of the shadow data port
`timescale 1ns/10ps
`default_nettype none
module tb_usdp_shadow_port
    import usdp_pkg::*;
;
    localparam int DEPTH = 4;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0]  rx_uart_byte, rx_ir_byte, tx_byte, b;
    logic        rx_uart_valid, rx_ir_valid, tx_uart_valid, tx_ir_valid;
    logic        tx_ready, ir_mode, irq;
    logic        stall = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  q[0:7];
    int          fails = 0;
    int          checks_done = 0;
    int          cyc = 0;
    usdp_shadow_port #(.DEPTH(DEPTH)) dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_uart_byte(rx_uart_byte), .rx_uart_valid(rx_uart_valid), .rx_ir_byte(rx_ir_byte),
        .rx_ir_valid(rx_ir_valid), .tx_byte(tx_byte), .tx_uart_valid(tx_uart_valid),
        .tx_ir_valid(tx_ir_valid), .tx_ready(tx_ready), .ir_mode(ir_mode), .irq(irq));
    usdp_peer peer (.clock(clock), .stall(stall), .slow(slow), .tx_byte(tx_byte),
        .tx_uart_valid(tx_uart_valid), .tx_ir_valid(tx_ir_valid), .tx_ready(tx_ready),
        .rx_uart_byte(rx_uart_byte), .rx_uart_valid(rx_uart_valid),
        .rx_ir_byte(rx_ir_byte), .rx_ir_valid(rx_ir_valid));
    initial begin
        forever #12.5 clock = ~clock;
    end
    function automatic logic [31:0] line_status_register(input logic dr, input logic oe, input logic th);
        return {26'h0, th, 3'h0, oe, dr};
    endfunction : line_status_register
    function automatic logic [31:0] alias_at(input logic [3:0] i);
        return USDP_ALIAS_BASE + {26'h0, i, 2'h0};
    endfunction : alias_at
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rc(input logic [31:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        chk(e, reg_rdata);
    endtask : rc
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(32'hE0A1BA45));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rc(USDP_LSR_ADDR, line_status_register(0, 0, 1));
        // Fill the buffer first; a never-written slot holds no defined byte
        peer.send(8'h00, 1'b0);
        rc(alias_at(7), 32'h0);
        rc(32'h5000_1180, 32'h0);
        $display("test 1 done");
        b = 8'($urandom);
        peer.send(b, 1'b0);
        peer.send(~b, 1'b0);
        rc(USDP_LSR_ADDR, line_status_register(1, 1, 1));
        rc(alias_at(8), {24'h0, ~b});
        wr(USDP_CTRL_ADDR, 32'h2);
        rc(USDP_CTRL_ADDR, 32'h2);
        peer.send(b, 1'b1);
        rc(USDP_LSR_ADDR, line_status_register(1, 0, 1));
        rc(alias_at(4'($urandom)), {24'h0, b});
        $display("test 2 done");
        stall <= 1'b1;
        rc(USDP_LSR_ADDR, line_status_register(0, 0, 1));
        wr(alias_at(7), 32'hFFFF_FF00 | b);
        wr(alias_at(8), {24'hA5A5A5, ~b});
        rc(USDP_LSR_ADDR, line_status_register(0, 0, 0));
        chk({24'h0, tx_byte}, {24'h0, ~b});
        chk({30'h0, tx_ir_valid, tx_uart_valid}, 32'h2);
        stall <= 1'b0;
        repeat (4) @(posedge clock);
        chk(32'(peer.got.size()), 32'h1);
        chk({24'h0, peer.got.pop_front()}, {24'h0, ~b});
        $display("test 3 done");
        wr(USDP_CTRL_ADDR, 32'h1);
        stall <= 1'b1;
        for (int i = 0; i < DEPTH + 2; i++) begin
            q[i] = 8'($urandom);
            wr(alias_at(4'(i)), {24'h0, q[i]});
        end
        @(posedge clock);
        #1;
        chk({31'h0, irq}, 32'h0);
        chk({30'h0, tx_ir_valid, tx_uart_valid}, 32'h1);
        wr(USDP_IMR_ADDR, 32'h8);
        @(posedge clock);
        #1;
        chk({31'h0, irq}, 32'h1);
        rc(USDP_ISR_ADDR, 32'hF);
        #1;
        chk({31'h0, irq}, 32'h0);
        rc(USDP_IMR_ADDR, 32'h8);
        slow  <= 1'b1;
        stall <= 1'b0;
        for (int n = 0; n < 40 && peer.got.size() < DEPTH; n++) @(posedge clock);
        repeat (4) @(posedge clock);
        chk(32'(peer.got.size()), 32'(DEPTH));
        for (int i = 0; i < DEPTH; i++) chk({24'h0, peer.got.pop_front()}, {24'h0, q[i]});
        $display("test 4 done");
        for (int i = 0; i <= DEPTH; i++) begin
            q[i] = 8'($urandom);
            peer.send(q[i], 1'b0);
        end
        rc(USDP_LSR_ADDR, line_status_register(1, 1, 1));
        for (int i = 0; i < DEPTH; i++) rc(alias_at(4'(i + 8)), {24'h0, q[i]});
        rc(USDP_LSR_ADDR, line_status_register(0, 0, 1));
        $display("test 5 done");
        end_sim();
    end
endmodule : tb_usdp_shadow_port
`default_nettype wire

// file: testbench/usdp_peer.sv
// Far-side serial peer: sends bytes in, takes bytes out
`timescale 1ns/10ps
`default_nettype none
module usdp_peer (
    input  wire logic       clock,
    input  wire logic       stall,
    input  wire logic       slow,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_uart_valid,
    input  wire logic       tx_ir_valid,
    output logic            tx_ready,
    output logic      [7:0] rx_uart_byte,
    output logic            rx_uart_valid,
    output logic      [7:0] rx_ir_byte,
    output logic            rx_ir_valid
);
    logic [7:0] got[$];
    logic       tick_ff = 1'b0;
    // Slow peer takes at most every other cycle
    assign tx_ready = !stall && (tick_ff || !slow);
    always @(posedge clock) begin
        tick_ff <= !tick_ff;
        if ((tx_uart_valid || tx_ir_valid) && tx_ready) got.push_back(tx_byte);
    end
    // Data lines flip after a byte so stale values never look valid
    task automatic send(input logic [7:0] b, input logic ir);
        @(posedge clock);
        rx_ir_byte    <= b;
        rx_uart_byte  <= b;
        rx_ir_valid   <= ir;
        rx_uart_valid <= !ir;
        @(posedge clock);
        rx_ir_valid   <= 1'b0;
        rx_uart_valid <= 1'b0;
        rx_ir_byte    <= ~b;
        rx_uart_byte  <= ~b;
    endtask : send
    initial begin
        rx_uart_byte  = 8'h00;
        rx_uart_valid = 1'b0;
        rx_ir_byte    = 8'h00;
        rx_ir_valid   = 1'b0;
    end
endmodule : usdp_peer
`default_nettype wire

// file: testbench/usdp_shadow_port_asserts.sv
// Port-level checker of the shadow data port
`timescale 1ns/10ps
`default_nettype none
module usdp_chk
    import usdp_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0]  rx_uart_byte,
    input wire logic        rx_uart_valid,
    input wire logic [7:0]  rx_ir_byte,
    input wire logic        rx_ir_valid,
    input wire logic [7:0]  tx_byte,
    input wire logic        tx_uart_valid,
    input wire logic        tx_ir_valid,
    input wire logic        tx_ready,
    input wire logic        ir_mode,
    input wire logic        irq
);
    logic fifo_on_ff;
    logic hit;
    logic line_status_register;
    logic tv;
    logic rxv;
    assign hit = reg_addr >= USDP_ALIAS_BASE && reg_addr <= USDP_ALIAS_LAST
                 && reg_addr[1:0] == 2'h0;
    assign line_status_register = reg_addr == USDP_LSR_ADDR;
    assign tv = tx_uart_valid || tx_ir_valid;
    assign rxv = ir_mode ? rx_ir_valid : rx_uart_valid;
    // Enable bit mirrored from bus writes, the block does not show it
    always_ff @(posedge clock) begin
        if (rst) begin
            fifo_on_ff <= 1'b0;
        end else if (reg_wr && reg_addr == USDP_CTRL_ADDR) begin
            fifo_on_ff <= reg_wdata[USDP_CTRL_FIFO_BIT];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    chk_reset_quiet: assert property ($past(rst) |-> !irq && !tv && !ir_mode)
        else $error("outputs not quiet after reset");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
    chk_upper_zero: assert property (reg_rd && hit |=> reg_rdata[31:8] == 24'h0)
        else $error("upper alias bits not zero");
    chk_mode_route: assert property (tv |-> tx_ir_valid == ir_mode && !(tx_uart_valid && tx_ir_valid))
        else $error("transmit on wrong output");
    chk_write_pends: assert property (reg_wr && hit && !tx_ready |=> tv)
        else $error("write left nothing pending");
    chk_hold_replace: assert property (reg_wr && hit && !fifo_on_ff && !tx_ready
        |=> tx_byte == 8'($past(reg_wdata))) else $error("holding byte not replaced");
    chk_hold_stable: assert property (tv && !tx_ready && !reg_wr |=> tv && $stable(tx_byte))
        else $error("pending byte lost while stalled");
    chk_rx_ready: assert property (rxv && !reg_rd && !reg_wr ##1 !reg_rd && !reg_wr
        ##1 reg_rd && line_status_register |=> reg_rdata[USDP_LSR_DR_BIT]) else $error("data ready missing");
    chk_transmit_holding_empty_flag_clear: assert property (reg_wr && hit && !tx_ready ##1 !tx_ready && !reg_wr
        ##1 reg_rd && line_status_register && !tx_ready |=> !reg_rdata[USDP_LSR_TRANSMIT_HOLDING_EMPTY_FLAG_BIT])
        else $error("holding empty flag still set");
endmodule : usdp_chk
bind usdp_shadow_port usdp_chk u_chk (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_uart_byte(rx_uart_byte), .rx_uart_valid(rx_uart_valid),
    .rx_ir_byte(rx_ir_byte), .rx_ir_valid(rx_ir_valid), .tx_byte(tx_byte),
    .tx_uart_valid(tx_uart_valid), .tx_ir_valid(tx_ir_valid),
    .tx_ready(tx_ready), .ir_mode(ir_mode), .irq(irq)
);
`default_nettype wire
